/* logic/deser_lock_pkg.sv */
/*
 * constants shared by the deserializer lock logic and its word buffer.
 * assumes a 100 MHz system clock and a separate serial bit clock at the link.
 */
// Operation
// (R1) each frame holds ten data bits framed by two embedded clock bits
// (R2) lock indicator goes high whenever lock to the stream is lost
// (R3) parallel outputs stay high-impedance until activity and lock are seen
// (R4) system keeps the reference clock running whenever lock is expected
// (R5) serializer sends sync patterns while either pattern request is high
// (R6) lock indicator stays high from power-up until lock, then goes low
// (R7) feeding lock indicator to a pattern request keeps patterns until lock
// (R8) lock is also found in ordinary data, with no sync patterns
// (R9) while lock indicator is low the output words are valid
// (R10) lock is dropped only after four consecutive bad clock fields
// (R11) up to three words before the drop may be corrupt, unmarked
// (R12) consumer treats three words before a loss as suspect after relock
// (R13) relock happens through resent patterns or random lock on data
// (R14) edge select: high means rising clock edge, low means falling edge
// (R15) output enable low puts data, lock and clock outputs in high-impedance
// (R16) sleep_n low stops clock recovery and floats every output; o_word_lost has no enable and stays driven
// (R17) while lock indicator is high, data and clock outputs float
// (R18) recovered clock gives exactly one word per twelve-bit frame
package deser_lock_pkg;
    // ****************************************
    // frame layout
    // ****************************************
    localparam int          FRAME_BITS  = 12;
    localparam int          DATA_BITS   = 10;
    localparam int          START_POS   = 11;
    localparam int          STOP_POS    = 0;
    localparam logic        START_VAL   = 1'b1;
    localparam logic        STOP_VAL    = 1'b0;
    localparam logic [3:0]  LAST_BIT    = 4'hb;
    localparam logic [3:0]  FIRST_BIT   = 4'h0;
    // ****************************************
    // lock detector counts
    // ****************************************
    localparam logic [2:0]  BAD_LIMIT   = 3'h4;
    localparam logic [3:0]  GOOD_LIMIT  = 4'h8;
    // ****************************************
    // recovered clock pacing (system cycles per half period)
    // ****************************************
    localparam logic [1:0]  PHASE_LAST  = 2'h3;
    localparam logic [1:0]  PHASE_EDGE  = 2'h2;
    localparam logic [9:0]  WORD_RESET  = 10'h000;
    localparam int          BUF_DEPTH   = 2;
endpackage

/* logic/word_cdc_fifo.sv */
/*
 * two-entry word buffer between the link clock and the system clock.
 * assumes both clocks run; pointers cross as gray code through three flops.
 */
`timescale 1ns/100ps
module word_cdc_fifo (
    input  wire logic                                 i_wclk,
    input  wire logic                                 i_rclk,
    input  wire logic                                 i_rst_b,
    input  wire logic [deser_lock_pkg::DATA_BITS-1:0] i_wdata,
    input  wire logic                                 i_wvalid,
    output logic                                      o_wready,
    output logic      [deser_lock_pkg::DATA_BITS-1:0] o_rdata,
    output logic                                      o_rvalid,
    input  wire logic                                 i_rready
);
    import deser_lock_pkg::*;

    logic [DATA_BITS-1:0] mem [BUF_DEPTH];
    logic [1:0]           wbin, next_wbin, wgray;
    logic [1:0]           rbin, next_rbin, rgray;
    logic [1:0]           rg1, rg2, rg3, rg_ok, next_rg_ok;
    logic [1:0]           wg1, wg2, wg3, wg_ok, next_wg_ok;
    logic                 do_wr, do_rd;

    // ****************************************
    // write side
    // ****************************************
    // full when the far pointer is one lap behind
    always_comb begin
        wgray      = wbin ^ (wbin >> 1);
        o_wready   = (wgray != ~rg_ok);
        do_wr      = i_wvalid && o_wready;
        next_wbin  = do_wr ? wbin + 2'h1 : wbin;
        next_rg_ok = (rg2 == rg3) ? rg3 : rg_ok; // accept once stages agree
    end

    always_ff @(posedge i_wclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wbin  <= 2'h0;
            rg1   <= 2'h0;
            rg2   <= 2'h0;
            rg3   <= 2'h0;
            rg_ok <= 2'h0;
        end else begin
            wbin  <= next_wbin;
            rg1   <= rgray;
            rg2   <= rg1;
            rg3   <= rg2;
            rg_ok <= next_rg_ok;
        end
    end

    // storage written only on the write clock
    always_ff @(posedge i_wclk) begin
        if (do_wr) begin
            mem[wbin[0]] <= i_wdata;
        end
    end

    // ****************************************
    // read side
    // ****************************************
    always_comb begin
        rgray      = rbin ^ (rbin >> 1);
        o_rvalid   = (rgray != wg_ok);
        o_rdata    = mem[rbin[0]];
        do_rd      = o_rvalid && i_rready;
        next_rbin  = do_rd ? rbin + 2'h1 : rbin;
        next_wg_ok = (wg2 == wg3) ? wg3 : wg_ok;
    end

    always_ff @(posedge i_rclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rbin  <= 2'h0;
            wg1   <= 2'h0;
            wg2   <= 2'h0;
            wg3   <= 2'h0;
            wg_ok <= 2'h0;
        end else begin
            rbin  <= next_rbin;
            wg1   <= wgray;
            wg2   <= wg1;
            wg3   <= wg2;
            wg_ok <= next_wg_ok;
        end
    end
endmodule

/* logic/deser_lock.sv */
/*
 * receiver lock detection, word framing and output gating of an
 * embedded-clock deserializer.
 * assumes the serial stream arrives sampled on its own bit clock, and that
 * the pad ring resolves each output from its active-low enable.
 */
`timescale 1ns/100ps
module deser_lock (
    input  wire logic                                 i_mclk,
    input  wire logic                                 i_rst_b,
    input  wire logic                                 i_link_clk,
    input  wire logic                                 i_serial_in,
    input  wire logic                                 i_rise_sel,
    input  wire logic                                 i_out_en,
    input  wire logic                                 i_sleep_n,
    output logic      [deser_lock_pkg::DATA_BITS-1:0] o_parallel_word_out,
    output logic                                      o_word_oe_n,
    output logic                                      o_rclk,
    output logic                                      o_rclk_oe_n,
    output logic                                      o_lock_n,
    output logic                                      o_lock_oe_n,
    output logic                                      o_word_lost
);
    import deser_lock_pkg::*;

    typedef enum logic {ST_HUNT, ST_LOCKED} lock_state_t;

    // ****************************************
    // link domain: sleep synchroniser
    // ****************************************
    logic sl1, sl2, sl3, sleep_link, next_sleep_link;

    always_comb begin
        next_sleep_link = (sl2 == sl3) ? sl3 : sleep_link;
    end

    always_ff @(posedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sl1        <= 1'b0;
            sl2        <= 1'b0;
            sl3        <= 1'b0;
            sleep_link <= 1'b0;
        end else begin
            sl1        <= i_sleep_n;
            sl2        <= sl1;
            sl3        <= sl2;
            sleep_link <= next_sleep_link;
        end
    end

    // ****************************************
    // link domain: framing and lock detector
    // ****************************************
    logic [FRAME_BITS-1:0] shreg, next_shreg, frame;
    logic [3:0]            bitcnt, next_bitcnt;
    logic [3:0]            good_cnt, next_good_cnt;
    logic [2:0]            bad_cnt, next_bad_cnt;
    lock_state_t           state, next_state;
    logic                  frame_end, frame_ok, wvalid, wready;
    logic                  lost, next_lost;

    // slip one bit per bad frame while hunting; count runs of good and bad
    always_comb begin
        frame         = {shreg[FRAME_BITS-2:0], i_serial_in};
        next_shreg    = frame;
        frame_end     = (bitcnt == LAST_BIT);
        frame_ok      = (frame[START_POS] == START_VAL) && (frame[STOP_POS] == STOP_VAL); // R1
        next_bitcnt   = frame_end ? FIRST_BIT : bitcnt + 4'h1;
        next_state    = state;
        next_good_cnt = good_cnt;
        next_bad_cnt  = bad_cnt;
        wvalid        = 1'b0;
        next_lost     = lost;
        if (!sleep_link) begin // R16
            next_state    = ST_HUNT;
            next_good_cnt = 4'h0;
            next_bad_cnt  = 3'h0;
            next_bitcnt   = FIRST_BIT;
        end else if (frame_end) begin
            case (state)
                ST_HUNT: begin
                    next_bad_cnt = 3'h0;
                    if (frame_ok) begin // R8 R13
                        next_good_cnt = good_cnt + 4'h1;
                        if (good_cnt == GOOD_LIMIT - 4'h1) begin
                            next_state    = ST_LOCKED;
                            next_good_cnt = 4'h0;
                        end
                    end else begin
                        next_good_cnt = 4'h0;
                        next_bitcnt   = LAST_BIT; // test again one bit later
                    end
                end
                ST_LOCKED: begin
                    wvalid    = 1'b1; // R18 R11
                    next_lost = lost ^ !wready; // toggle, so the slower clock cannot miss it
                    if (frame_ok) begin
                        next_bad_cnt = 3'h0;
                    end else if (bad_cnt == BAD_LIMIT - 3'h1) begin // R10
                        next_state   = ST_HUNT;
                        next_bad_cnt = 3'h0;
                    end else begin
                        next_bad_cnt = bad_cnt + 3'h1;
                    end
                end
                default: begin
                    next_state = ST_HUNT;
                end
            endcase
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shreg    <= '0;
            bitcnt   <= FIRST_BIT;
            good_cnt <= 4'h0;
            bad_cnt  <= 3'h0;
            state    <= ST_HUNT;
            lost     <= 1'b0;
        end else begin
            shreg    <= next_shreg;
            bitcnt   <= next_bitcnt;
            good_cnt <= next_good_cnt;
            bad_cnt  <= next_bad_cnt;
            state    <= next_state;
            lost     <= next_lost;
        end
    end

    // ****************************************
    // word buffer across the clock boundary
    // ****************************************
    logic [DATA_BITS-1:0] rdata;
    logic                 rvalid, rready;

    word_cdc_fifo u_buf (
        .i_wclk   (i_link_clk),
        .i_rclk   (i_mclk),
        .i_rst_b  (i_rst_b),
        .i_wdata  (frame[START_POS-1:STOP_POS+1]),
        .i_wvalid (wvalid),
        .o_wready (wready),
        .o_rdata  (rdata),
        .o_rvalid (rvalid),
        .i_rready (rready)
    );

    // ****************************************
    // system domain: pin and status synchronisers
    // ****************************************
    logic [3:0] s1, s2, s3, sync_q, next_sync_q;
    logic       lock_m, sleep_m, en_m, rise_m;

    // each level changes once the second and third stage agree
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            next_sync_q[k] = (s2[k] == s3[k]) ? s3[k] : sync_q[k];
        end
        lock_m  = sync_q[0];
        sleep_m = sync_q[1];
        en_m    = sync_q[2];
        rise_m  = sync_q[3];
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1     <= 4'h0;
            s2     <= 4'h0;
            s3     <= 4'h0;
            sync_q <= 4'h0;
        end else begin
            s1     <= {i_rise_sel, i_out_en, i_sleep_n, state == ST_LOCKED};
            s2     <= s1;
            s3     <= s2;
            sync_q <= next_sync_q;
        end
    end

    // ****************************************
    // system domain: word pacing, recovered clock, gating
    // ****************************************
    logic [1:0]           phase, next_phase;
    logic                 busy, next_busy;
    logic [DATA_BITS-1:0] next_word;
    logic                 next_rclk, next_lock_n, next_lock_oe_n, next_word_oe_n, lost1, lost2, lost3, next_lost_out;

    // one word per recovered clock period; data changes away from the strobe edge
    always_comb begin
        rready         = !busy;
        next_busy      = busy;
        next_phase     = phase;
        next_word      = o_parallel_word_out;
        next_rclk      = o_rclk;
        if (!busy && rvalid) begin // R18
            next_busy  = 1'b1;
            next_phase = 2'h0;
            next_word  = rdata; // R9
            next_rclk  = !rise_m; // R14
        end else if (busy) begin
            next_phase = phase + 2'h1;
            if (phase + 2'h1 == PHASE_EDGE) begin
                next_rclk = rise_m; // R14
            end
            if (phase == PHASE_LAST) begin
                next_busy = 1'b0;
            end
        end
        next_lock_n    = !lock_m; // R2 R6
        next_lock_oe_n = !(sleep_m && en_m); // R15 R16
        next_word_oe_n = !(sleep_m && en_m && lock_m); // R3 R17
        next_lost_out  = lost2 != lost3;
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy                <= 1'b0;
            phase               <= 2'h0;
            o_parallel_word_out <= WORD_RESET;
            o_rclk              <= 1'b0;
            o_lock_n            <= 1'b1;
            o_lock_oe_n         <= 1'b1;
            o_word_oe_n         <= 1'b1;
            o_rclk_oe_n         <= 1'b1;
            lost1               <= 1'b0;
            lost2               <= 1'b0;
            lost3               <= 1'b0;
            o_word_lost         <= 1'b0;
        end else begin
            busy                <= next_busy;
            phase               <= next_phase;
            o_parallel_word_out <= next_word;
            o_rclk              <= next_rclk;
            o_lock_n            <= next_lock_n;
            o_lock_oe_n         <= next_lock_oe_n;
            o_word_oe_n         <= next_word_oe_n;
            o_rclk_oe_n         <= next_word_oe_n;
            lost1               <= lost;
            lost2               <= lost1;
            lost3               <= lost2;
            o_word_lost         <= next_lost_out;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    property p_bad_four;
        @(posedge i_link_clk) disable iff (!i_rst_b)
        (state == ST_LOCKED && sleep_link && frame_end && !frame_ok && bad_cnt == 3'h3) |=> state == ST_HUNT;
    endproperty
    a_bad_four: assert property (p_bad_four) else $error("lock kept after four bad frames"); // R10

    property p_bad_short;
        @(posedge i_link_clk) disable iff (!i_rst_b)
        (state == ST_LOCKED && sleep_link && bad_cnt < 3'h3) |=> state == ST_LOCKED;
    endproperty
    a_bad_short: assert property (p_bad_short) else $error("lock dropped too early"); // R10

    property p_random_lock;
        @(posedge i_link_clk) disable iff (!i_rst_b)
        (state == ST_HUNT && sleep_link && frame_end && frame_ok && good_cnt == 4'h7) |=> state == ST_LOCKED;
    endproperty
    a_random_lock: assert property (p_random_lock) else $error("no lock after good frames"); // R8

    property p_one_word;
        @(posedge i_link_clk) disable iff (!i_rst_b)
        wvalid |-> frame_end && state == ST_LOCKED ##1 !wvalid;
    endproperty
    a_one_word: assert property (p_one_word) else $error("word written off frame"); // R18

    property p_sleep_hunt;
        @(posedge i_link_clk) disable iff (!i_rst_b)
        !sleep_link |=> state == ST_HUNT && bitcnt == FIRST_BIT;
    endproperty
    a_sleep_hunt: assert property (p_sleep_hunt) else $error("recovery runs asleep"); // R16

    property p_lock_flag;
        @(posedge i_mclk) disable iff (!i_rst_b)
        $fell(lock_m) |=> o_lock_n && o_word_oe_n && o_rclk_oe_n;
    endproperty
    a_lock_flag: assert property (p_lock_flag) else $error("loss not flagged"); // R2

    property p_float_unlocked;
        @(posedge i_mclk) disable iff (!i_rst_b)
        o_lock_n |-> o_word_oe_n && o_rclk_oe_n;
    endproperty
    a_float_unlocked: assert property (p_float_unlocked) else $error("outputs driven unlocked"); // R17

    property p_out_en;
        @(posedge i_mclk) disable iff (!i_rst_b)
        !(en_m && sleep_m) |=> o_lock_oe_n && o_word_oe_n && o_rclk_oe_n;
    endproperty
    a_out_en: assert property (p_out_en) else $error("outputs driven while disabled"); // R15

    property p_edge;
        @(posedge i_mclk) disable iff (!i_rst_b)
        (!busy && rvalid && rise_m) |=> !o_rclk ##2 o_rclk;
    endproperty
    a_edge: assert property (p_edge) else $error("strobe edge wrong"); // R14
endmodule

/* bench/serializer_model.sv */
/*
 * behavioural serializer: frames queued words with two embedded clock bits.
 * assumes a free-running link clock; the receiver samples on its rising edge.
 */
`timescale 1ns/100ps
module serializer_model #(
    parameter logic [9:0] SYNC_WORD = 10'h3e0,
    parameter logic [9:0] IDLE_WORD = 10'h2b5
) (
    input  wire logic i_link_clk,
    input  wire logic i_pattern_request_a,
    input  wire logic i_pattern_request_b,
    output logic      o_serial
);
    logic [10:0] pend[$];
    logic [10:0] ent;
    logic [11:0] shift;
    logic [11:0] nxt;
    logic [3:0]  bitn;

    // queue one word; a bad frame carries inverted clock bits
    function automatic void push(input logic bad, input logic [9:0] word);
        pend.push_back({bad, word});
    endfunction

    initial begin
        o_serial = 1'b0;
        shift = 12'h000;
        bitn = 4'h0;
    end

    // ****************************************
    // frame shifter, start bit first
    // ****************************************
    always @(posedge i_link_clk) begin
        if (bitn == 4'h0) begin
            if (i_pattern_request_a | i_pattern_request_b) begin
                nxt = {1'b1, SYNC_WORD, 1'b0};
            end else if (pend.size() > 0) begin
                ent = pend.pop_front();
                nxt = ent[10] ? {1'b0, ent[9:0], 1'b1} : {1'b1, ent[9:0], 1'b0};
            end else begin
                nxt = {1'b1, IDLE_WORD, 1'b0};
            end
            shift <= nxt;
            o_serial <= nxt[11];
        end else begin
            o_serial <= shift[4'hb - bitn];
        end
        bitn <= (bitn == 4'hb) ? 4'h0 : bitn + 4'h1;
    end
endmodule

/* bench/tb_deser_lock.sv */
/*
 * testbench of the deserializer lock logic against a serializer model.
 * assumes the design's own assertions run alongside it.
 */
`timescale 1ns/100ps
module tb_deser_lock;
    import deser_lock_pkg::*;
    logic                 i_mclk, i_rst_b, i_link_clk, i_rise_sel, i_out_en, i_sleep_n;
    logic                 fb_en, pat_b, req_a, serial, prev_rclk;
    logic [DATA_BITS-1:0] word_out;
    logic                 word_oe_n, rclk, rclk_oe_n, lock_n, lock_oe_n, word_lost;
    logic [9:0]           cap[$];
    int                   fails, checks, cycles, lost;

    // lock indicator fed back as a pattern request
    assign req_a = fb_en & lock_n;

    deser_lock deser_lock_i (
        .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_link_clk(i_link_clk), .i_serial_in(serial),
        .i_rise_sel(i_rise_sel), .i_out_en(i_out_en), .i_sleep_n(i_sleep_n),
        .o_parallel_word_out(word_out), .o_word_oe_n(word_oe_n), .o_rclk(rclk),
        .o_rclk_oe_n(rclk_oe_n), .o_lock_n(lock_n), .o_lock_oe_n(lock_oe_n), .o_word_lost(word_lost)
    );
    serializer_model ser_i (
        .i_link_clk(i_link_clk), .i_pattern_request_a(req_a), .i_pattern_request_b(pat_b), .o_serial(serial)
    );

    // ****************************************
    // clocks, monitor and timeout
    // ****************************************
    initial i_mclk = 1'b0;
    always #5 i_mclk = ~i_mclk;
    initial i_link_clk = 1'b0;
    always begin
        #1.3;
        forever #3 i_link_clk = ~i_link_clk;
    end
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        prev_rclk <= rclk;
        if (word_oe_n === 1'b0 && rclk === i_rise_sel && prev_rclk !== i_rise_sel) cap.push_back(word_out);
        if (word_lost === 1'b1) lost++;
        if (cycles == 40000) begin
            fails++;
            end_sim();
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic ok, input string msg);
        checks++;
        if (!ok) begin
            fails++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    // wait for a lock level; words must never drive while unlocked
    task automatic wait_lock(input logic lv, input int lim, input string msg);
        int n;
        int leak;
        n = 0;
        leak = 0;
        while (lock_n !== lv && n < lim) begin
            @(posedge i_mclk);
            if (lock_n !== 1'b0 && word_oe_n === 1'b0) leak++;
            n++;
        end
        chk(lock_n === lv, msg);
        chk(leak == 0, "words driven while unlocked");
    endtask
    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_words(input logic sel, input logic [9:0] base);
        logic [9:0] got[$];
        int k;
        i_rise_sel <= sel;
        repeat (20) @(posedge i_mclk);
        cap.delete();
        for (k = 0; k < 6; k++) ser_i.push(1'b0, base + 10'(k));
        repeat (90) @(posedge i_mclk);
        foreach (cap[j]) if (cap[j] - base < 10'h6) got.push_back(cap[j]);
        chk(got.size() == 6, "word count");
        for (k = 0; k < got.size() && k < 6; k++) chk(got[k] === base + 10'(k), "word value");
    endtask
    task automatic t_out_en;
        i_out_en <= 1'b0;
        repeat (8) @(posedge i_mclk);
        chk(lock_oe_n === 1'b1 && word_oe_n === 1'b1 && rclk_oe_n === 1'b1, "drives with enable low");
        i_out_en <= 1'b1;
        repeat (8) @(posedge i_mclk);
        chk(lock_oe_n === 1'b0 && word_oe_n === 1'b0 && rclk_oe_n === 1'b0, "no drive after enable");
    endtask
    task automatic t_loss;
        int k;
        int hi;
        int n_ok;
        fb_en <= 1'b0;
        hi = 0;
        n_ok = 0;
        cap.delete();
        for (k = 0; k < 3; k++) ser_i.push(1'b1, 10'h155);
        for (k = 0; k < 4; k++) ser_i.push(1'b0, 10'h0aa);
        repeat (120) begin
            @(posedge i_mclk);
            if (lock_n !== 1'b0) hi++;
        end
        chk(hi == 0, "lock dropped after three bad frames");
        // words of the bad frames are suspect and skipped; only clean words are judged
        foreach (cap[j]) if (cap[j] === 10'h0aa) n_ok++;
        chk(n_ok == 4, "clean words lost around short fault");
        for (k = 0; k < 4; k++) ser_i.push(1'b1, 10'h155);
        wait_lock(1'b1, 150, "lock kept after four bad frames");
        repeat (10) @(posedge i_mclk);
        chk(word_oe_n === 1'b1 && rclk_oe_n === 1'b1, "drives after loss");
        wait_lock(1'b0, 4000, "no random lock on data");
    endtask
    task automatic t_sleep;
        i_sleep_n <= 1'b0;
        pat_b <= 1'b1;
        repeat (20) @(posedge i_mclk);
        chk(lock_oe_n === 1'b1 && word_oe_n === 1'b1 && rclk_oe_n === 1'b1, "drives in sleep");
        i_sleep_n <= 1'b1;
        fb_en <= 1'b1;
        wait_lock(1'b1, 40, "lock survived sleep");
        wait_lock(1'b0, 3000, "no relock on patterns");
        pat_b <= 1'b0;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        i_rst_b = 1'b0;
        i_rise_sel = 1'b1;
        i_out_en = 1'b1;
        i_sleep_n = 1'b1;
        fb_en = 1'b1;
        pat_b = 1'b0;
        prev_rclk = 1'b0;
        repeat (5) @(posedge i_mclk);
        chk(lock_n === 1'b1 && word_oe_n === 1'b1 && rclk_oe_n === 1'b1, "outputs live in reset");
        i_rst_b <= 1'b1;
        wait_lock(1'b0, 2000, "no lock on patterns");
        repeat (10) @(posedge i_mclk);
        chk(word_oe_n === 1'b0 && rclk_oe_n === 1'b0 && lock_oe_n === 1'b0, "no drive when locked");
        t_words(1'b1, 10'h000);
        t_words(1'b0, 10'h3fa);
        t_out_en();
        t_loss();
        t_sleep();
        t_words(1'b1, 10'h200);
        chk(lost == 0, "word dropped");
        end_sim();
    end
endmodule
